/* inc/tick_timer_pkg.sv */
// Constants, register map and carrier types for the tick timer block.
// Assumes an APB slave with 32-bit data, byte addresses, one word per register.
package tick_timer_pkg;

  // ==========================================================
  // Register byte offsets
  localparam logic [11:0] ctrl_status_offset = 12'h010;
  localparam logic [11:0] reload_offset = 12'h014;
  localparam logic [11:0] count_value_offset = 12'h018;
  localparam logic [11:0] calibration_offset = 12'h01c;
  localparam logic [11:0] enable_set_low_offset = 12'h100;

  // ==========================================================
  // Field positions
  localparam int count_width = 24;
  localparam int ctrl_enable_bit = 0;
  localparam int ctrl_tick_irq_bit = 1;
  localparam int ctrl_clk_source_bit = 2;
  localparam int ctrl_wrap_seen_bit = 16;
  localparam int cal_no_ref_bit = 31;
  localparam int cal_inexact_bit = 30;

  // ==========================================================
  // Fixed values
  localparam logic [23:0] ten_ms_reload_cal = 24'h0009c4;
  localparam logic [31:0] enable_set_low_mask = 32'hffff8fff;
  localparam logic [23:0] count_zero = 24'h000000;
  localparam logic [23:0] count_one = 24'h000001;

  // ==========================================================
  // Tick clock derivation
  localparam int tick_divide = 32;
  localparam int osc_sync_stages = 2;

  // ==========================================================
  // Carrier: the control fields of the control and status register
  typedef struct packed {
    logic enable;
    logic tick_irq_enable;
    logic clk_source;
  } ctrl_type;

endpackage

/* design/osc_sync.sv */
// Two-flop synchroniser for the main oscillator input pin.
// Assumes the pin is asynchronous to pclk and slower than pclk/2.
`timescale 1ns/10ps
module osc_sync (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Pin in, synchronised level out
  input wire logic async_in,
  output logic sync_out
);

  // First stage is read only by the second stage
  logic stage1;

  // ==========================================================
  // Synchroniser flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1 <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end

endmodule

/* design/tick_divider.sv */
// Divides rising edges of the synchronised oscillator by a fixed ratio.
// Assumes the input is already on pclk; emits one-cycle tick pulses.
`timescale 1ns/10ps
module tick_divider #(
  parameter int divide = tick_timer_pkg::tick_divide
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Synchronised oscillator level
  input wire logic osc_level,
  // One pclk pulse per divide oscillator cycles
  output logic tick
);

  localparam int cnt_w = (divide > 1) ? $clog2(divide) : 1;
  localparam logic [cnt_w-1:0] last = cnt_w'(divide - 1);

  // Elaboration check: a ratio below two leaves no room to count
  if (divide < 2) begin : g_bad_divide
    $error("tick_divider: divide must be at least 2");
  end

  logic osc_prev; // Last sampled level for edge finding
  logic [cnt_w-1:0] cnt; // Edges seen in this period
  logic next_osc_prev;
  logic [cnt_w-1:0] next_cnt;
  logic next_tick;

  // ==========================================================
  // Edge count and wrap
  always_comb begin
    next_osc_prev = osc_level;
    next_cnt = cnt;
    next_tick = 1'b0;
    if (osc_level && !osc_prev) begin
      // Rising edge of the oscillator
      if (cnt == last) begin
        next_cnt = '0;
        next_tick = 1'b1;
      end else begin
        next_cnt = cnt + 1'b1;
      end
    end
  end

  // Register stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_prev <= 1'b0;
      cnt <= '0;
      tick <= 1'b0;
    end else begin
      osc_prev <= next_osc_prev;
      cnt <= next_cnt;
      tick <= next_tick;
    end
  end

endmodule

/* design/tick_timer.sv */
// Tick timer with count value, reload, calibration word and the lower
// interrupt set-enable bank, reached over APB.
// Assumes main_osc_input is an asynchronous pin well below pclk/2.
// Behaviour notes
// - The slave answers every transfer in its first access cycle.
// - Unmapped addresses answer with an error, read zero, ignore writes.
// - The calibration word is fixed; writes to it are dropped silently.
// - Bits 14-12 of the enable bank never set, whatever is written.
// - Reaching zero means a tick that takes the count from one; a tick
//   at zero (after a count write) only reloads and sets no flag.
// - A wrap in the same cycle as a read or a count write still sets
//   the wrap-seen flag, so software never loses an event.
// - The clock-source bit is stored and read back only; the timer
//   always runs from the divided oscillator.
// - The oscillator is seen three pclk cycles late through the
//   synchroniser and edge finder; tick spacing is unaffected.
// - The oscillator must stay well below half of pclk so that every
//   level is held for at least two samples.
//
// The placing of the registers and the APB register port were left to the implementer.
`timescale 1ns/10ps
module tick_timer #(
  parameter logic no_ref_clock_flag = 1'b0,
  parameter logic cal_inexact_flag = 1'b0
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Oscillator pin
  input wire logic main_osc_input,
  // Tick exception pend and enables to the interrupt controller
  output logic tick_pend,
  output logic [31:0] irq_enable_set
);

  // ==========================================================
  // Declarations
  logic osc_level; // Synchronised oscillator
  logic tick; // One pulse per 32 oscillator cycles
  tick_timer_pkg::ctrl_type ctrl; // Control fields
  tick_timer_pkg::ctrl_type next_ctrl;
  logic wrap_seen; // Sticky reached-zero flag
  logic next_wrap_seen;
  logic [23:0] reload; // Reload value, undefined at reset in spirit; zero here
  logic [23:0] next_reload;
  logic [23:0] count; // Present count
  logic [23:0] next_count;
  logic [31:0] next_irq_enable_set;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic next_tick_pend;
  logic access; // Access phase of a transfer
  logic wr; // Write takes effect this edge
  logic rd; // Read data taken this edge
  logic hit_count; // Count register addressed
  logic wrap; // Count wraps at this tick
  logic mapped; // Address decodes to a register

  // ==========================================================
  // Elaboration checks
  // The read mux and the calibration word assume the package count
  // width; a package edit that changes it must fail here, not later
  if ($bits(count) != tick_timer_pkg::count_width) begin : g_bad_count_width
    $error("tick_timer: count width must match the package");
  end
  if ($bits(reload) != tick_timer_pkg::count_width) begin : g_bad_reload_width
    $error("tick_timer: reload width must match the package");
  end

  // ==========================================================
  // Oscillator path
  osc_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(main_osc_input),
    .sync_out(osc_level)
  );

  // Divide by 32 to form the tick clock enable
  tick_divider #(
    .divide(tick_timer_pkg::tick_divide)
  ) u_div (
    .pclk(pclk),
    .presetn(presetn),
    .osc_level(osc_level),
    .tick(tick)
  );

  // ==========================================================
  // Bus decode
  // The slave answers in the first access cycle, so pready is the
  // registered copy of setup; zero wait states seen from the master.
  assign access = psel && penable && pready;
  assign wr = access && pwrite;
  assign rd = access && !pwrite;
  assign hit_count = (paddr == tick_timer_pkg::count_value_offset);
  assign wrap = ctrl.enable && tick && (count == tick_timer_pkg::count_one);
  always_comb begin
    unique case (paddr)
      tick_timer_pkg::ctrl_status_offset,
      tick_timer_pkg::reload_offset,
      tick_timer_pkg::count_value_offset,
      tick_timer_pkg::calibration_offset,
      tick_timer_pkg::enable_set_low_offset: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // ==========================================================
  // Handshake: ready in the cycle after setup
  always_comb begin
    next_pready = psel && !penable;
    // The error flag only ever rises together with pready
    next_pslverr = psel && !penable && !mapped;
  end

  // ==========================================================
  // Read mux, registered in the setup cycle so prdata is a flop
  always_comb begin
    next_prdata = 32'h00000000;
    if (psel && !penable && !pwrite) begin
      unique case (paddr)
        tick_timer_pkg::ctrl_status_offset: begin
          next_prdata[tick_timer_pkg::ctrl_enable_bit] = ctrl.enable;
          next_prdata[tick_timer_pkg::ctrl_tick_irq_bit] = ctrl.tick_irq_enable;
          next_prdata[tick_timer_pkg::ctrl_clk_source_bit] = ctrl.clk_source;
          // Includes a wrap landing this cycle so a read never misses it
          next_prdata[tick_timer_pkg::ctrl_wrap_seen_bit] = wrap_seen || wrap;
        end
        tick_timer_pkg::reload_offset: begin
          next_prdata[23:0] = reload;
        end
        tick_timer_pkg::count_value_offset: begin
          next_prdata[23:0] = count;
        end
        tick_timer_pkg::calibration_offset: begin
          next_prdata[tick_timer_pkg::cal_no_ref_bit] = no_ref_clock_flag;
          next_prdata[tick_timer_pkg::cal_inexact_bit] = cal_inexact_flag;
          next_prdata[23:0] = tick_timer_pkg::ten_ms_reload_cal;
        end
        tick_timer_pkg::enable_set_low_offset: begin
          next_prdata = irq_enable_set;
        end
        default: begin
          next_prdata = 32'h00000000;
        end
      endcase
    end
  end

  // ==========================================================
  // Control, reload and enable bank writes
  always_comb begin
    next_ctrl = ctrl;
    next_reload = reload;
    next_irq_enable_set = irq_enable_set;
    if (wr && paddr == tick_timer_pkg::ctrl_status_offset) begin
      next_ctrl.enable = pwdata[tick_timer_pkg::ctrl_enable_bit];
      next_ctrl.tick_irq_enable = pwdata[tick_timer_pkg::ctrl_tick_irq_bit];
      next_ctrl.clk_source = pwdata[tick_timer_pkg::ctrl_clk_source_bit];
    end
    if (wr && paddr == tick_timer_pkg::reload_offset) begin
      next_reload = pwdata[23:0];
    end
    if (wr && paddr == tick_timer_pkg::enable_set_low_offset) begin
      // Ones set, zeros leave alone; unassigned bits never set
      next_irq_enable_set = irq_enable_set
        | (pwdata & tick_timer_pkg::enable_set_low_mask);
    end
  end

  // ==========================================================
  // Counter and wrap-seen flag
  always_comb begin
    next_count = count;
    next_wrap_seen = wrap_seen;
    next_tick_pend = 1'b0;
    // Enable from off loads the reload value before the first tick
    if (wr && paddr == tick_timer_pkg::ctrl_status_offset
        && pwdata[tick_timer_pkg::ctrl_enable_bit] && !ctrl.enable) begin
      next_count = reload;
    end else if (ctrl.enable && tick) begin
      // A tick at zero reloads too, so a cleared count restarts cleanly
      if (count == tick_timer_pkg::count_zero
          || count == tick_timer_pkg::count_one) begin
        next_count = reload;
      end else begin
        next_count = count - tick_timer_pkg::count_one;
      end
    end
    // Clear by read of the control register
    if (rd && paddr == tick_timer_pkg::ctrl_status_offset) begin
      next_wrap_seen = 1'b0;
    end
    // Any count write forces zero and drops the flag
    if (wr && hit_count) begin
      next_count = tick_timer_pkg::count_zero;
      next_wrap_seen = 1'b0;
    end
    // A wrap in the same cycle as a clear still sets the flag
    if (wrap) begin
      next_wrap_seen = 1'b1;
      next_tick_pend = ctrl.tick_irq_enable;
    end
  end

  // ==========================================================
  // Register stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= '0;
      // Reload and count have no defined reset value; zero keeps the
      // read path free of unknowns
      reload <= tick_timer_pkg::count_zero;
      count <= tick_timer_pkg::count_zero;
      wrap_seen <= 1'b0;
      irq_enable_set <= 32'h00000000;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      tick_pend <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      reload <= next_reload;
      count <= next_count;
      wrap_seen <= next_wrap_seen;
      irq_enable_set <= next_irq_enable_set;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      tick_pend <= next_tick_pend;
    end
  end

endmodule

/* tb/tick_timer_asserts.sv */
// Checker for the tick timer APB answers, calibration word and enable bank.
// Sees only the top module ports; attached by the bind at the foot.
`timescale 1ns/10ps
module tick_timer_asserts #(
  parameter logic no_ref_clock_flag = 1'b0,
  parameter logic cal_inexact_flag = 1'b0
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Timer and enables
  input wire logic main_osc_input,
  input wire logic tick_pend,
  input wire logic [31:0] irq_enable_set
);
  // ==========================================================
  // Helpers
  logic rd_ok; // A good read answer is on the bus
  logic en_wr; // A write to the set-enable bank lands at this edge
  assign rd_ok = pready && !pwrite && !pslverr;
  assign en_wr = psel && penable && pready && pwrite
    && paddr == tick_timer_pkg::enable_set_low_offset;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================
  // Properties
  ans_after_setup_a: assert property (psel && !penable |=> pready && psel && penable)
    else $error("no answer after setup");
  ready_pulse_a: assert property (pready |=> !pready) else $error("ready held");
  idle_rdata_a: assert property (!pready |-> prdata == 32'h0) else $error("data while idle");
  err_zero_a: assert property (pslverr |-> pready && prdata == 32'h0) else $error("bad error");
  count_upper_a: assert property (rd_ok && paddr == tick_timer_pkg::count_value_offset
    |-> prdata[31:24] == 8'h00) else $error("count upper bits");
  cal_word_a: assert property (rd_ok && paddr == tick_timer_pkg::calibration_offset
    |-> prdata == {no_ref_clock_flag, cal_inexact_flag, 6'h00, 24'h0009c4})
    else $error("calibration word");
  en_set_a: assert property (en_wr |=> irq_enable_set ==
    ($past(irq_enable_set) | ($past(pwdata) & 32'hffff8fff))) else $error("enable set");
  en_hold_a: assert property (!en_wr |=> $stable(irq_enable_set)) else $error("enable moved");
  en_read_a: assert property (rd_ok && paddr == tick_timer_pkg::enable_set_low_offset
    |-> prdata == irq_enable_set) else $error("enable read");
  pend_pulse_a: assert property (tick_pend |=> !tick_pend) else $error("pend held");
endmodule

bind tick_timer tick_timer_asserts #(.no_ref_clock_flag(no_ref_clock_flag),
  .cal_inexact_flag(cal_inexact_flag)) chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .main_osc_input(main_osc_input),
  .tick_pend(tick_pend), .irq_enable_set(irq_enable_set));

/* tb/tick_timer_tb.sv */
// Self-checking bench for the tick timer: APB master tasks and a small model.
// Assumes the checker is bound in; the oscillator pin is made here.
`timescale 1ns/10ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
  $display("MISMATCH %s expected %h seen %h", n, e, g); end end
module tick_timer_tb;
  // ==========================================================
  // Signals and model state
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic main_osc_input = 1'b0, osc_run = 1'b0, pready, pslverr, tick_pend, er;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, irq_enable_set, rd, v;
  logic [31:0] en_model = 32'h0; // Expected enable bank
  int err_count = 0, cmp_count = 0, cyc = 0, pends = 0, t_last = 0, t_prev = 0, n;
  tick_timer #(.no_ref_clock_flag(1'b1), .cal_inexact_flag(1'b0)) DUT (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .main_osc_input(main_osc_input), .tick_pend(tick_pend), .irq_enable_set(irq_enable_set));
  initial forever #4 pclk = ~pclk;
  // Oscillator at a quarter of pclk, pend timing, and the hang limit
  always @(posedge pclk) begin
    cyc++;
    if (osc_run && cyc % 2 == 0) main_osc_input <= ~main_osc_input;
    if (tick_pend === 1'b1) begin
      pends++;
      t_prev = t_last;
      t_last = cyc;
    end
    if (cyc == 20000) begin
      err_count++;
      give_verdict();
    end
  end
  // ==========================================================
  // One APB transfer; holds the request until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Ends when pready is sampled high, or at the bench timeout
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, $urandom);
    `CHK("read", e, rd)
  endtask
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    v = $urandom(65092);
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rchk(tick_timer_pkg::calibration_offset, 32'h800009c4);
    apb(1'b1, tick_timer_pkg::calibration_offset, $urandom);
    rchk(tick_timer_pkg::calibration_offset, 32'h800009c4);
    rchk(tick_timer_pkg::enable_set_low_offset, 32'h0);
    apb(1'b0, 12'h0f0, 32'h0);
    `CHK("unmapped error", 1'b1, er)
    `CHK("unmapped data", 32'h0, rd)
    $display("test reset values done");
    // Random ones set, zeros leave alone, 14-12 never set
    for (int i = 0; i < 6; i++) begin
      v = $urandom;
      apb(1'b1, tick_timer_pkg::enable_set_low_offset, v);
      en_model = en_model | (v & 32'hffff8fff);
      rchk(tick_timer_pkg::enable_set_low_offset, en_model);
      `CHK("enable port", en_model, irq_enable_set)
    end
    $display("test set-enable done");
    // Oscillator still, so the loaded count is seen exactly
    apb(1'b1, tick_timer_pkg::reload_offset, 32'h3);
    apb(1'b1, tick_timer_pkg::ctrl_status_offset, 32'h1);
    rchk(tick_timer_pkg::count_value_offset, 32'h3);
    osc_run <= 1'b1;
    pends = 0;
    repeat (800) @(posedge pclk);
    `CHK("pend while masked", 0, pends)
    rchk(tick_timer_pkg::ctrl_status_offset, 32'h00010001);
    rchk(tick_timer_pkg::ctrl_status_offset, 32'h00000001);
    apb(1'b1, tick_timer_pkg::ctrl_status_offset, 32'h3);
    pends = 0;
    n = 0;
    while (pends < 2 && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    `CHK("pend count", 2, pends)
    `CHK("wrap interval", 3 * tick_timer_pkg::tick_divide * 4, t_last - t_prev)
    $display("test timer done");
    // Stop, then clear the count by a write while wrap-seen is set
    apb(1'b1, tick_timer_pkg::ctrl_status_offset, 32'h4);
    apb(1'b1, tick_timer_pkg::count_value_offset, $urandom);
    rchk(tick_timer_pkg::count_value_offset, 32'h0);
    rchk(tick_timer_pkg::ctrl_status_offset, 32'h4);
    rchk(tick_timer_pkg::reload_offset, 32'h3);
    $display("test count clear done");
    // Reset in mid-run drops every enable
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    en_model = 32'h0;
    `CHK("enable after reset", en_model, irq_enable_set)
    rchk(tick_timer_pkg::enable_set_low_offset, en_model);
    $display("test mid-run reset done");
    give_verdict();
  end
endmodule
